/* verilog/yrc_pkg.sv */
// Shared constants and types for the converter output formatting stage
`default_nettype none

package yrc_pkg;

	// ==========================================================
	// Register map, as word indices; byte address is index * 4
	localparam int unsigned ADDR_W = 16;
	localparam logic [13:0] CTRL_IDX = 14'h3000;
	localparam logic [13:0] FIX_IDX = 14'h300e;
	localparam logic [13:0] STAT_IDX = 14'h3010;

	// ==========================================================
	// Control register fields
	localparam int unsigned BYP_BIT = 15;
	localparam int unsigned FMT_BIT = 9;
	localparam int unsigned RSVD_BIT = 8;
	localparam int unsigned SWRST_BIT = 7;
	localparam int unsigned FIX_LSB = 5;
	localparam logic [15:0] CTRL_RST = 16'h0405;
	// Bit 8 and undocumented bits 14, 13 and 3 never store
	localparam logic [15:0] CTRL_WMASK = 16'h9ef7;

	// ==========================================================
	// Fixed chroma register fields
	localparam int unsigned FIX_U_LSB = 8;
	localparam int unsigned FIX_V_LSB = 0;
	localparam logic [15:0] FIX_RST = 16'h0000;

	// ==========================================================
	// Status register fields
	localparam int unsigned STAT_HOLD_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT = 1;
	localparam int unsigned STAT_CNT_LSB = 16;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [7:0] y0;
		logic [7:0] y1;
		logic [7:0] u;
		logic [7:0] v;
	} yrc_pair_t;

	typedef struct packed {
		logic [15:0] first;
		logic [15:0] second;
	} yrc_words_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FIRST,
		ST_SECOND
	} yrc_state_t;

endpackage

`default_nettype wire

/* verilog/yrc_skid.sv */
// Two-entry buffer with valid and ready on both sides
`default_nettype none

module yrc_skid #(
	parameter int unsigned W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);

	logic out_valid_r;
	logic [W-1:0] out_data_r;
	logic skid_valid_r;
	logic [W-1:0] skid_data_r;
	logic in_fire;

	// Ready comes from a flop so no combinational path reaches the source
	assign in_ready = !skid_valid_r;
	assign in_fire = in_valid && !skid_valid_r;
	assign out_valid = out_valid_r;
	assign out_data = out_data_r;

	// ==========================================================
	// Storage
	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_r <= 1'b0;
			out_data_r <= '0;
			skid_valid_r <= 1'b0;
			skid_data_r <= '0;
		end else if (!out_valid_r || out_ready) begin
			if (skid_valid_r) begin
				out_data_r <= skid_data_r;
				out_valid_r <= 1'b1;
				skid_valid_r <= 1'b0;
			end else if (in_fire) begin
				out_data_r <= in_data;
				out_valid_r <= 1'b1;
			end else begin
				out_valid_r <= 1'b0;
			end
		end else if (in_fire) begin
			skid_data_r <= in_data;
			skid_valid_r <= 1'b1;
		end
	end

endmodule

`default_nettype wire

/* verilog/yrc_out_fmt.sv */
// Converter control registers and bypass output formatting to memory
`default_nettype none

// Overview of operation
// - Format applies only to memory write path
// - Format bit honoured only while bypassed
// - Format 0: V/Y odd, then U/Y even
// - Format 1: Y even/U, then Y odd/V
// - Control bit 8 reserved, reads zero
// - Reset bit clears logic, keeps registers
// - Writing zero to reset bit: releases logic
// - Fix field replaces U, V, or both
// - Chroma fix applies even when bypassed
module yrc_out_fmt (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [yrc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [yrc_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Pixel pairs in
	input wire logic pix_valid,
	input wire yrc_pkg::yrc_pair_t pix_pair,
	output logic pix_ready,
	// Words out to memory writer
	output logic sdram_valid,
	output logic [15:0] sdram_data,
	input wire logic sdram_ready
);

	// ==========================================================
	// Declarations
	logic [15:0] ctrl_r;
	logic [15:0] fix_r;
	logic aw_have_r;
	logic [13:0] aw_idx_r;
	logic w_have_r;
	logic [15:0] w_data_r;
	logic [1:0] w_strb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic do_write;
	logic [15:0] wr_merge;
	logic hold;
	logic dp_rst;
	yrc_pkg::yrc_state_t state_r;
	yrc_pkg::yrc_state_t state_nxt;
	logic pix_ready_r;
	logic take;
	yrc_pkg::yrc_words_t words_r;
	yrc_pkg::yrc_words_t words_nxt;
	logic [7:0] u_eff;
	logic [7:0] v_eff;
	logic fmt_sel;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [15:0] buf_in_data;
	logic push;
	logic [15:0] word_cnt_r;

	// ==========================================================
	// Bus write channel: address and data taken in either order
	assign do_write = aw_have_r && w_have_r && !bvalid_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awready_r <= 1'b0;
			aw_have_r <= 1'b0;
			aw_idx_r <= '0;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_have_r <= 1'b1;
			aw_idx_r <= s_axi_awaddr[15:2];
		end else if (do_write) begin
			aw_have_r <= 1'b0;
		end else if (!aw_have_r && !bvalid_r) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wready_r <= 1'b0;
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata[15:0];
			w_strb_r <= s_axi_wstrb[1:0];
		end else if (do_write) begin
			w_have_r <= 1'b0;
		end else if (!w_have_r && !bvalid_r) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bvalid_r <= 1'b0;
			bresp_r <= yrc_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			if (aw_idx_r == yrc_pkg::CTRL_IDX || aw_idx_r == yrc_pkg::FIX_IDX ||
				aw_idx_r == yrc_pkg::STAT_IDX) begin
				bresp_r <= yrc_pkg::RESP_OKAY;
			end else begin
				bresp_r <= yrc_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ==========================================================
	// Registers; byte lanes 0 and 1 carry the 16-bit fields
	always_comb begin
		wr_merge = (aw_idx_r == yrc_pkg::CTRL_IDX) ? ctrl_r : fix_r;
		if (w_strb_r[0]) begin
			wr_merge[7:0] = w_data_r[7:0];
		end
		if (w_strb_r[1]) begin
			wr_merge[15:8] = w_data_r[15:8];
		end
	end

	// Only the bus and the system reset change these; the software reset never touches them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= yrc_pkg::CTRL_RST;
			fix_r <= yrc_pkg::FIX_RST;
		end else if (do_write) begin
			if (aw_idx_r == yrc_pkg::CTRL_IDX) begin
				ctrl_r <= wr_merge & yrc_pkg::CTRL_WMASK;
			end else if (aw_idx_r == yrc_pkg::FIX_IDX) begin
				fix_r <= wr_merge;
			end
		end
	end

	// ==========================================================
	// Bus read channel
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= yrc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= yrc_pkg::RESP_OKAY;
			if (s_axi_araddr[15:2] == yrc_pkg::CTRL_IDX) begin
				rdata_r <= {16'h0000, ctrl_r};
			end else if (s_axi_araddr[15:2] == yrc_pkg::FIX_IDX) begin
				rdata_r <= {16'h0000, fix_r};
			end else if (s_axi_araddr[15:2] == yrc_pkg::STAT_IDX) begin
				rdata_r <= '0;
				rdata_r[yrc_pkg::STAT_HOLD_BIT] <= hold;
				rdata_r[yrc_pkg::STAT_BUSY_BIT] <= (state_r != yrc_pkg::ST_IDLE);
				rdata_r[yrc_pkg::STAT_CNT_LSB +: 16] <= word_cnt_r;
			end else begin
				rdata_r <= '0;
				rresp_r <= yrc_pkg::RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ==========================================================
	// Software reset: a level, not a pulse, so logic stays quiet
	// until software writes the bit back to zero
	assign hold = ctrl_r[yrc_pkg::SWRST_BIT];
	assign dp_rst = sys_rst || hold;

	// ==========================================================
	// Chroma substitution ahead of the packer, bypassed or not
	assign u_eff = ctrl_r[yrc_pkg::FIX_LSB] ? fix_r[yrc_pkg::FIX_U_LSB +: 8] : pix_pair.u;
	assign v_eff = ctrl_r[yrc_pkg::FIX_LSB+1] ? fix_r[yrc_pkg::FIX_V_LSB +: 8] : pix_pair.v;

	// Format bit counts only in bypass; otherwise the default order
	assign fmt_sel = ctrl_r[yrc_pkg::BYP_BIT] && ctrl_r[yrc_pkg::FMT_BIT];

	always_comb begin
		if (fmt_sel) begin
			words_nxt.first = {pix_pair.y0, u_eff};
			words_nxt.second = {pix_pair.y1, v_eff};
		end else begin
			words_nxt.first = {v_eff, pix_pair.y1};
			words_nxt.second = {u_eff, pix_pair.y0};
		end
	end

	// ==========================================================
	// Packer sequence: one pair in, two words out
	assign take = pix_valid && pix_ready_r;
	assign buf_in_valid = (state_r == yrc_pkg::ST_FIRST) || (state_r == yrc_pkg::ST_SECOND);
	assign buf_in_data = (state_r == yrc_pkg::ST_FIRST) ? words_r.first : words_r.second;
	assign push = buf_in_valid && buf_in_ready;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			yrc_pkg::ST_IDLE: begin
				if (take) begin
					state_nxt = yrc_pkg::ST_FIRST;
				end
			end
			yrc_pkg::ST_FIRST: begin
				if (push) begin
					state_nxt = yrc_pkg::ST_SECOND;
				end
			end
			yrc_pkg::ST_SECOND: begin
				if (push) begin
					state_nxt = yrc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = yrc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (dp_rst) begin
			state_r <= yrc_pkg::ST_IDLE;
			pix_ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pix_ready_r <= (state_nxt == yrc_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (dp_rst) begin
			words_r <= '0;
		end else if (take) begin
			words_r <= words_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (dp_rst) begin
			word_cnt_r <= '0;
		end else if (push) begin
			word_cnt_r <= word_cnt_r + 16'h0001;
		end
	end

	assign pix_ready = pix_ready_r;

	// ==========================================================
	// Memory write path; a stalled writer backs up into the packer
	yrc_skid #(
		.W(16)
	) u_skid (
		.clk(clk),
		.rst(dp_rst),
		.in_valid(buf_in_valid),
		.in_data(buf_in_data),
		.in_ready(buf_in_ready),
		.out_valid(sdram_valid),
		.out_data(sdram_data),
		.out_ready(sdram_ready)
	);

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// A step in the cycle the reset bit lands is flushed by it, so it is left out
	sequence seq_take_byp_fmt0;
		take && !hold && ctrl_r[yrc_pkg::BYP_BIT] && !ctrl_r[yrc_pkg::FMT_BIT];
	endsequence
	sequence seq_take_byp_fmt1;
		take && !hold && ctrl_r[yrc_pkg::BYP_BIT] && ctrl_r[yrc_pkg::FMT_BIT];
	endsequence
	sequence seq_hold_two;
		hold [*2];
	endsequence
	sequence seq_first_pushed;
		(state_r == yrc_pkg::ST_FIRST) && push && !hold;
	endsequence

	AST_VYUY_ORDER: assert property (
		seq_take_byp_fmt0 |=> words_r.first[7:0] == $past(pix_pair.y1) &&
			words_r.second[7:0] == $past(pix_pair.y0))
		else $error("VYUY order wrong");
	AST_YUYV_ORDER: assert property (
		seq_take_byp_fmt1 |=> words_r.first[15:8] == $past(pix_pair.y0) &&
			words_r.second[15:8] == $past(pix_pair.y1))
		else $error("YUYV order wrong");
	AST_FMT_IGNORED: assert property (
		take && !hold && !ctrl_r[yrc_pkg::BYP_BIT] |=> words_r.first[7:0] == $past(pix_pair.y1))
		else $error("Format bit used while converter active");
	AST_FIX_U: assert property (
		seq_take_byp_fmt1 and (ctrl_r[yrc_pkg::FIX_LSB] && !hold)
		|=> words_r.first[7:0] == $past(fix_r[15:8]))
		else $error("U not replaced by fixed value");
	AST_FIX_V_BYPASS: assert property (
		seq_take_byp_fmt0 and (ctrl_r[yrc_pkg::FIX_LSB+1] && !hold)
		|=> words_r.first[15:8] == $past(fix_r[7:0]))
		else $error("V not replaced in bypass");
	AST_RSVD_ZERO: assert property (
		rvalid_r && $past(s_axi_araddr[15:2] == yrc_pkg::CTRL_IDX && arready_r &&
			s_axi_arvalid) |-> rdata_r[yrc_pkg::RSVD_BIT] == 1'b0)
		else $error("Reserved bit reads one");
	AST_SWRST_HOLD: assert property (
		seq_hold_two |-> state_r == yrc_pkg::ST_IDLE && !pix_ready_r && !sdram_valid)
		else $error("Logic not held during software reset");
	AST_SWRST_KEEPS_REGS: assert property (
		hold && !do_write |=> fix_r == $past(fix_r) && ctrl_r == $past(ctrl_r))
		else $error("Software reset changed a register");
	AST_PAIR_SEQUENCE: assert property (
		seq_first_pushed |=> state_r == yrc_pkg::ST_SECOND ##1
			(state_r == yrc_pkg::ST_SECOND || state_r == yrc_pkg::ST_IDLE || hold))
		else $error("Word pair sequence broken");
	AST_WRITE_ANSWER: assert property (
		do_write |=> bvalid_r [*1] ##0 (!aw_have_r && !w_have_r))
		else $error("Write not answered in one cycle");

endmodule

`default_nettype wire

/* tb/yrc_sdram_model.sv */
// Memory-side sink model that takes the converter's output words
`default_nettype none

module yrc_sdram_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Stall mode: 0 prompt, 1 every other cycle, 2 blocked
	input wire logic [1:0] mode,
	// Word stream
	input wire logic sdram_valid,
	input wire logic [15:0] sdram_data,
	output logic sdram_ready
);
	timeunit 1ns;
	timeprecision 1ns;

	// ========
	// Accepted words, oldest first
	logic [15:0] q[$];

	always_ff @(posedge clk) begin
		if (sys_rst)
			sdram_ready <= 1'b0;
		else
			sdram_ready <= (mode == 2'h0) | ((mode == 2'h1) & ~sdram_ready);
	end

	// Only the memory write path lands here, so every word seen is formatted output
	always @(posedge clk) begin
		if (!sys_rst && sdram_valid && sdram_ready)
			q.push_back(sdram_data);
	end
endmodule

`default_nettype wire

/* tb/yuv_bypass_output_uv_fix_tb.sv */
// Self-checking bench for the converter control and output formatting stage
`default_nettype none

module yuv_bypass_output_uv_fix_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ========
	// Addresses and constants
	localparam logic [15:0] A_CTRL = {yrc_pkg::CTRL_IDX, 2'b00};
	localparam logic [15:0] A_FIX = {yrc_pkg::FIX_IDX, 2'b00};
	localparam logic [15:0] A_STAT = {yrc_pkg::STAT_IDX, 2'b00};
	localparam logic [15:0] FIXV = 16'ha55a;
	localparam logic [1:0] OK = yrc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = yrc_pkg::RESP_SLVERR;
	localparam int LIMIT = 5000;

	// ========
	// Signals
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pix_valid = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic [1:0] mode = 2'h0;
	yrc_pkg::yrc_pair_t pix_pair = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic pix_ready, sdram_valid, sdram_ready;
	logic [15:0] sdram_data;
	int mismatches = 0, num_checks = 0, cycles = 0;

	yrc_out_fmt uut (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pix_valid, .pix_pair,
		.pix_ready, .sdram_valid, .sdram_data, .sdram_ready);
	yrc_sdram_model sink (.clk, .sys_rst, .mode, .sdram_valid, .sdram_data, .sdram_ready);

	always #25 clk = ~clk;

	// A hang is cut short here rather than left to the simulator
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			stop_test();
		end
	end

	// ========
	// Compare and report
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t response %h expected %h", $time, got, exp);
		end
	endtask

	// ========
	// Bus and stream drivers
	task automatic axi_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				chk_resp(s_axi_bresp, er);
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				chk_val(s_axi_rdata, ed);
				chk_resp(s_axi_rresp, er);
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	// Offers one pair for at most lim edges; a refused pair is withdrawn
	task automatic send(input yrc_pkg::yrc_pair_t p, input int lim, output logic tk);
		tk = 1'b0;
		@(posedge clk);
		pix_pair <= p;
		pix_valid <= 1'b1;
		for (int i = 0; i < lim && !tk; i++) begin
			@(posedge clk);
			if (pix_ready)
				tk = 1'b1;
		end
		pix_valid <= 1'b0;
	endtask

	function automatic logic [31:0] exp_words(input logic [15:0] c, input yrc_pkg::yrc_pair_t p);
		logic [7:0] u;
		logic [7:0] v;
		u = c[5] ? FIXV[15:8] : p.u;
		v = c[6] ? FIXV[7:0] : p.v;
		if (c[15] && c[9])
			return {p.y0, u, p.y1, v};
		return {v, p.y1, u, p.y0};
	endfunction

	task automatic take2(input logic [15:0] c, input yrc_pkg::yrc_pair_t p);
		logic [31:0] w;
		w = exp_words(c, p);
		while (sink.q.size() < 2)
			@(posedge clk);
		chk_val({16'h0000, sink.q.pop_front()}, {16'h0000, w[31:16]});
		chk_val({16'h0000, sink.q.pop_front()}, {16'h0000, w[15:0]});
	endtask

	// ========
	// Test sequence
	initial begin
		logic tk;
		logic [15:0] c;
		yrc_pkg::yrc_pair_t p;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		axi_rd(A_CTRL, {16'h0000, yrc_pkg::CTRL_RST}, OK);
		axi_rd(A_FIX, 32'h00000000, OK);
		axi_rd(16'h0100, 32'h00000000, ERR);
		axi_wr(16'h0100, 16'hffff, ERR);
		axi_wr(A_CTRL, 16'hff7f, OK);
		axi_rd(A_CTRL, 32'h00009e77, OK);
		s_axi_wstrb <= 4'h1;
		axi_wr(A_FIX, 16'hffff, OK);
		s_axi_wstrb <= 4'h3;
		axi_rd(A_FIX, 32'h000000ff, OK);
		axi_wr(A_FIX, FIXV, OK);
		axi_rd(A_FIX, {16'h0000, FIXV}, OK);
		for (int k = 0; k < 16; k++) begin
			c = {k[3], 5'h00, k[2], 2'b00, k[1:0], 5'h05};
			p = {4'h1, k[3:0], 4'h2, k[3:0], 4'h3, k[3:0], 4'h4, k[3:0]};
			mode <= {1'b0, k[0]};
			axi_wr(A_CTRL, c, OK);
			send(p, 50, tk);
			take2(c, p);
		end
		axi_wr(A_STAT, 16'hffff, OK);
		axi_rd(A_STAT, 32'h00200000, OK);
		// Fill the buffer against a blocked sink, then drain it
		c = 16'h8220;
		p = 32'h01020304;
		axi_wr(A_CTRL, c, OK);
		mode <= 2'h2;
		send(p, 50, tk);
		send(~p, 50, tk);
		send(p, 10, tk);
		chk_val({31'h0, tk}, 32'h00000000);
		axi_rd(A_STAT, 32'h00220002, OK);
		axi_wr(A_CTRL, c, OK);
		mode <= 2'h0;
		send(p, 50, tk);
		take2(c, p);
		take2(c, ~p);
		take2(c, p);
		// Software reset while words are still queued
		mode <= 2'h2;
		send(p, 50, tk);
		send(~p, 50, tk);
		axi_wr(A_CTRL, c | 16'h0080, OK);
		axi_rd(A_CTRL, {16'h0000, c | 16'h0080}, OK);
		axi_rd(A_FIX, {16'h0000, FIXV}, OK);
		axi_rd(A_STAT, 32'h00000001, OK);
		mode <= 2'h0;
		send(p, 10, tk);
		chk_val({31'h0, tk}, 32'h00000000);
		chk_val(32'(sink.q.size()), 32'h00000000);
		axi_wr(A_CTRL, c, OK);
		send(p, 50, tk);
		take2(c, p);
		chk_val(32'(sink.q.size()), 32'h00000000);
		stop_test();
	end
endmodule

`default_nettype wire
